// >>> src/branch_inc_pkg.sv
`default_nettype none

package branch_inc_pkg;

  // widths
  localparam int INSTR_W    = 14;
  localparam int PC_W       = 13;
  localparam int LIT_W      = 11;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int PHASE_N    = 4;

  // instruction word fields
  localparam int JUMP_OP_MSB   = 13;
  localparam int JUMP_OP_LSB   = 11;
  localparam int INCREMENT_FILE_INSTR_OP_MSB   = 13;
  localparam int INCREMENT_FILE_INSTR_OP_LSB   = 8;
  localparam int DEST_BIT      = 7;
  localparam int FADDR_MSB     = 6;
  localparam int LIT_MSB       = 10;

  localparam logic [2:0] JUMP_OPCODE = 3'h5;
  localparam logic [5:0] INCREMENT_FILE_INSTR_OPCODE = 6'h0a;

  // page latch bits feeding the program counter top
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;

  // phase positions in the one-hot phase word
  localparam int PH_ONE   = 0;
  localparam int PH_TWO   = 1;
  localparam int PH_THREE = 2;
  localparam int PH_FOUR  = 3;

  // reset values and fixed constants
  localparam logic [PHASE_N-1:0] PHASE_RESET   = 4'h8;
  localparam logic [PC_W-1:0]    PC_RESET      = 13'h0000;
  localparam logic [PC_W-1:0]    PC_STEP       = 13'h0001;
  localparam logic [DATA_W-1:0]  DATA_RESET    = 8'h00;
  localparam logic [DATA_W-1:0]  DATA_ONE      = 8'h01;
  localparam logic [DATA_W-1:0]  DATA_ZERO     = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RESET   = 14'h0000;
  localparam logic [LIT_W-1:0]   LIT_RESET     = 11'h000;
  localparam logic [FADDR_W-1:0] FADDR_RESET   = 7'h00;

  typedef enum logic [0:0] {
    RUN_ST,
    REFILL_ST
  } cycle_state_t;

endpackage : branch_inc_pkg

`default_nettype wire

// >>> src/phase_if.sv
`default_nettype none

interface phase_if;
  import branch_inc_pkg::*;

  logic [PHASE_N-1:0] phase_now;
  logic [PHASE_N-1:0] phase_next;

  modport gen (output phase_now, output phase_next);
  modport use_side (input phase_now, input phase_next);
endinterface : phase_if

`default_nettype wire

// >>> src/phase_gen.sv
`default_nettype none

module phase_gen
  import branch_inc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  phase_if.gen      ph
);

  logic [PHASE_N-1:0] phase_q;
  logic [PHASE_N-1:0] phase_d;

  // one-hot rotation, so exactly one phase is live in every cycle
  always_comb begin
    phase_d = {phase_q[PHASE_N-2:0], phase_q[PHASE_N-1]};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= PHASE_RESET;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign ph.phase_now  = phase_q;
  assign ph.phase_next = phase_d;

endmodule // phase_gen

`default_nettype wire

// >>> src/branch_and_increment_decode.sv
`default_nettype none

//  Operation
// - A decoded jump copies the eleven-bit literal of the instruction into the low pc bits.
// - During a jump the two top pc bits come from bits four and three of the page latch.
// - A jump takes two instruction cycles, the second doing nothing in all four phases.
// - The jump is unconditional and leaves every status flag as it was.
// - An increment reads the addressed file register, adds one and writes it in one cycle.
// - With the destination bit clear the sum goes to the working register only.
// - With the destination bit set the sum goes back into the same file register.
module branch_and_increment_decode
  import branch_inc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic [INSTR_W-1:0] instr_word,
  input  wire logic [DATA_W-1:0]  pc_page_latch,
  input  wire logic [DATA_W-1:0]  file_rd_data,
  output var  logic               phase_one,
  output var  logic               phase_two,
  output var  logic               phase_three,
  output var  logic               phase_four,
  output var  logic [PC_W-1:0]    pc_q,
  output var  logic               pc_load_q,
  output var  logic [FADDR_W-1:0] file_addr_q,
  output var  logic               file_rd_en_q,
  output var  logic               file_wr_en_q,
  output var  logic               w_wr_en_q,
  output var  logic [DATA_W-1:0]  result_data_q,
  output var  logic               zero_flag_q,
  output var  logic               zero_wr_en_q,
  output var  logic               nop_cycle_q
);

  function automatic logic is_jump(input logic [INSTR_W-1:0] w);
    is_jump = (w[JUMP_OP_MSB:JUMP_OP_LSB] == JUMP_OPCODE);
  endfunction

  function automatic logic is_increment_file_instr(input logic [INSTR_W-1:0] w);
    is_increment_file_instr = (w[INCREMENT_FILE_INSTR_OP_MSB:INCREMENT_FILE_INSTR_OP_LSB] == INCREMENT_FILE_INSTR_OPCODE);
  endfunction

  // 8-bit add drops the carry, giving the wrap at 256
  function automatic logic [DATA_W-1:0] inc8(input logic [DATA_W-1:0] v);
    inc8 = v + DATA_ONE;
  endfunction

  phase_if ph ();

  phase_gen u_phase_gen (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ph      (ph)
  );

  logic [INSTR_W-1:0] ir_q;
  logic [INSTR_W-1:0] ir_d;
  logic [INSTR_W-1:0] cur_word;
  cycle_state_t       state_q;
  cycle_state_t       state_d;
  logic               run_now;
  logic               jump_go;
  logic               increment_file_instr_go;
  logic [LIT_W-1:0]   literal_q;
  logic [LIT_W-1:0]   literal_d;
  logic [1:0]         page_q;
  logic [1:0]         page_d;
  logic [DATA_W-1:0]  operand_q;
  logic [DATA_W-1:0]  operand_d;
  logic [DATA_W-1:0]  sum;
  logic [PC_W-1:0]    pc_d;
  logic               pc_load_d;
  logic [FADDR_W-1:0] file_addr_d;
  logic               file_rd_en_d;
  logic               file_wr_en_d;
  logic               w_wr_en_d;
  logic [DATA_W-1:0]  result_data_d;
  logic               zero_flag_d;
  logic               zero_wr_en_d;
  logic               nop_cycle_d;
  logic [PHASE_N-1:0] phase_q;

  // the word is only guaranteed on the bus during phase one
  always_comb begin
    cur_word = ph.phase_now[PH_ONE] ? instr_word : ir_q;
    ir_d     = cur_word;
    run_now  = (state_q == RUN_ST);
    jump_go  = run_now && is_jump(cur_word);
    increment_file_instr_go  = run_now && is_increment_file_instr(cur_word);
    sum      = inc8(operand_q);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_q <= INSTR_RESET;
    end else begin
      ir_q <= ir_d;
    end
  end

  // cycle state: a jump forces one dead refill cycle
  always_comb begin
    state_d = state_q;
    if (ph.phase_now[PH_FOUR]) begin
      unique case (state_q)
        RUN_ST:    state_d = jump_go ? REFILL_ST : RUN_ST;
        REFILL_ST: state_d = RUN_ST;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RUN_ST;
    end else begin
      state_q <= state_d;
    end
  end

  // jump operands, caught in phase two
  always_comb begin
    literal_d = literal_q;
    page_d    = page_q;
    if (ph.phase_now[PH_TWO] && jump_go) begin
      literal_d = cur_word[LIT_MSB:0];
      page_d    = pc_page_latch[PAGE_HI:PAGE_LO];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      literal_q <= LIT_RESET;
      page_q    <= 2'h0;
    end else begin
      literal_q <= literal_d;
      page_q    <= page_d;
    end
  end

  // file read: address from phase one, strobe in phase two
  always_comb begin
    file_addr_d  = file_addr_q;
    operand_d    = operand_q;
    file_rd_en_d = ph.phase_next[PH_TWO] && increment_file_instr_go;
    if (ph.phase_now[PH_ONE] && increment_file_instr_go) begin
      file_addr_d = cur_word[FADDR_MSB:0];
    end
    if (ph.phase_now[PH_TWO] && file_rd_en_q) begin
      operand_d = file_rd_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_addr_q  <= FADDR_RESET;
      file_rd_en_q <= 1'b0;
      operand_q    <= DATA_RESET;
    end else begin
      file_addr_q  <= file_addr_d;
      file_rd_en_q <= file_rd_en_d;
      operand_q    <= operand_d;
    end
  end

  // phase four write-back of the increment
  always_comb begin
    file_wr_en_d  = 1'b0;
    w_wr_en_d     = 1'b0;
    zero_wr_en_d  = 1'b0;
    result_data_d = result_data_q;
    zero_flag_d   = zero_flag_q;
    if (ph.phase_next[PH_FOUR] && increment_file_instr_go) begin
      result_data_d = sum;
      file_wr_en_d  = cur_word[DEST_BIT];
      w_wr_en_d     = !cur_word[DEST_BIT];
      zero_wr_en_d  = 1'b1;
      zero_flag_d   = (sum == DATA_ZERO);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wr_en_q  <= 1'b0;
      w_wr_en_q     <= 1'b0;
      zero_wr_en_q  <= 1'b0;
      result_data_q <= DATA_RESET;
      zero_flag_q   <= 1'b0;
    end else begin
      file_wr_en_q  <= file_wr_en_d;
      w_wr_en_q     <= w_wr_en_d;
      zero_wr_en_q  <= zero_wr_en_d;
      result_data_q <= result_data_d;
      zero_flag_q   <= zero_flag_d;
    end
  end

  // program counter: loads on a jump cycle, else steps once per cycle, refill cycle included
  always_comb begin
    pc_d      = pc_q;
    pc_load_d = 1'b0;
    if (ph.phase_next[PH_FOUR]) begin
      if (jump_go) begin
        pc_d      = {page_q, literal_q};
        pc_load_d = 1'b1;
      end else begin
        pc_d = pc_q + PC_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q      <= PC_RESET;
      pc_load_q <= 1'b0;
    end else begin
      pc_q      <= pc_d;
      pc_load_q <= pc_load_d;
    end
  end

  // nop flag spans all four phases of the refill cycle
  always_comb begin
    nop_cycle_d = nop_cycle_q;
    if (ph.phase_next[PH_ONE]) begin
      nop_cycle_d = (state_d == REFILL_ST);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nop_cycle_q <= 1'b0;
      phase_q     <= PHASE_RESET;
    end else begin
      nop_cycle_q <= nop_cycle_d;
      phase_q     <= ph.phase_next;
    end
  end

  // local copy keeps the phase outputs straight off flops
  assign phase_one   = phase_q[PH_ONE];
  assign phase_two   = phase_q[PH_TWO];
  assign phase_three = phase_q[PH_THREE];
  assign phase_four  = phase_q[PH_FOUR];

endmodule // branch_and_increment_decode

`default_nettype wire

// >>> verif/branch_inc_monitor.sv
`default_nettype none

module branch_inc_monitor
  import branch_inc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rst_b,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [DATA_W-1:0]  pc_page_latch,
  input wire logic [DATA_W-1:0]  file_rd_data,
  input wire logic               phase_one,
  input wire logic               phase_two,
  input wire logic               phase_three,
  input wire logic               phase_four,
  input wire logic [PC_W-1:0]    pc_q,
  input wire logic               pc_load_q,
  input wire logic [FADDR_W-1:0] file_addr_q,
  input wire logic               file_rd_en_q,
  input wire logic               file_wr_en_q,
  input wire logic               w_wr_en_q,
  input wire logic [DATA_W-1:0]  result_data_q,
  input wire logic               zero_flag_q,
  input wire logic               zero_wr_en_q,
  input wire logic               nop_cycle_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // read data is only valid in the read cycle, so keep a copy for the sum check
  logic [DATA_W-1:0] file_rd_data_d1;
  logic [DATA_W-1:0] file_rd_data_d2;
  always_ff @(posedge ref_clk) begin
    file_rd_data_d1 <= file_rd_en_q ? file_rd_data : file_rd_data_d1;
    file_rd_data_d2 <= file_rd_data_d1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence refill_s;
    nop_cycle_q [*4] ##1 !nop_cycle_q;
  endsequence

  sequence write_s;
    zero_wr_en_q && phase_four && (file_wr_en_q ^ w_wr_en_q);
  endsequence

  phase_onehot_a: assert property (
    $onehot({phase_one, phase_two, phase_three, phase_four}))
    else $error("phase word not one-hot");
  phase_ring_a: assert property (phase_four |=> phase_one)
    else $error("phase one does not follow phase four");
  jump_target_a: assert property (
    pc_load_q |-> phase_four && pc_q[10:0] == $past(instr_word[10:0], 3))
    else $error("jump literal not in pc");
  jump_page_a: assert property (
    pc_load_q |-> pc_q[12:11] == $past(pc_page_latch[4:3], 2))
    else $error("jump page bits wrong");
  jump_refill_a: assert property (pc_load_q |=> refill_s)
    else $error("refill cycle not four phases");
  flag_hold_a: assert property (!zero_wr_en_q |-> $stable(zero_flag_q))
    else $error("zero flag changed without increment");
  inc_walk_a: assert property (file_rd_en_q |-> phase_two ##2 write_s)
    else $error("increment walk broken");
  inc_dest_a: assert property (
    file_rd_en_q |-> ##2 file_wr_en_q == $past(instr_word[7], 3))
    else $error("increment destination wrong");
  inc_addr_a: assert property (file_rd_en_q |-> file_addr_q == $past(instr_word[6:0]))
    else $error("file address wrong");
  inc_sum_a: assert property (
    file_rd_en_q |-> ##2 result_data_q == 8'(file_rd_data_d2 + 8'h01))
    else $error("increment sum wrong");
  zero_val_a: assert property (zero_wr_en_q |-> zero_flag_q == (result_data_q == 8'h00))
    else $error("zero flag value wrong");
endmodule // branch_inc_monitor

bind branch_and_increment_decode branch_inc_monitor u_branch_inc_monitor (
  .ref_clk       (ref_clk),
  .rst_b         (rst_b),
  .instr_word    (instr_word),
  .pc_page_latch (pc_page_latch),
  .file_rd_data  (file_rd_data),
  .phase_one     (phase_one),
  .phase_two     (phase_two),
  .phase_three   (phase_three),
  .phase_four    (phase_four),
  .pc_q          (pc_q),
  .pc_load_q     (pc_load_q),
  .file_addr_q   (file_addr_q),
  .file_rd_en_q  (file_rd_en_q),
  .file_wr_en_q  (file_wr_en_q),
  .w_wr_en_q     (w_wr_en_q),
  .result_data_q (result_data_q),
  .zero_flag_q   (zero_flag_q),
  .zero_wr_en_q  (zero_wr_en_q),
  .nop_cycle_q   (nop_cycle_q)
);

`default_nettype wire

// >>> verif/tb_branch_and_increment_decode.sv
`default_nettype none

module tb_branch_and_increment_decode
  import branch_inc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, phase_one, phase_two, phase_three, phase_four;
  logic pc_load_q, file_rd_en_q, file_wr_en_q, w_wr_en_q, zero_flag_q, zero_wr_en_q, nop_cycle_q;
  logic [INSTR_W-1:0] instr_word;
  logic [DATA_W-1:0]  pc_page_latch, file_rd_data, result_data_q;
  logic [PC_W-1:0]    pc_q, exp_pc;
  logic [FADDR_W-1:0] file_addr_q;
  logic               rd_seen;
  int failures, cmp_count;

  branch_and_increment_decode u_branch_and_increment_decode (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .instr_word    (instr_word),
    .pc_page_latch (pc_page_latch),
    .file_rd_data  (file_rd_data),
    .phase_one     (phase_one),
    .phase_two     (phase_two),
    .phase_three   (phase_three),
    .phase_four    (phase_four),
    .pc_q          (pc_q),
    .pc_load_q     (pc_load_q),
    .file_addr_q   (file_addr_q),
    .file_rd_en_q  (file_rd_en_q),
    .file_wr_en_q  (file_wr_en_q),
    .w_wr_en_q     (w_wr_en_q),
    .result_data_q (result_data_q),
    .zero_flag_q   (zero_flag_q),
    .zero_wr_en_q  (zero_wr_en_q),
    .nop_cycle_q   (nop_cycle_q)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("cmp_count=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // drives one word for a whole instruction cycle, returns inside phase four
  task automatic issue(input logic [13:0] w, input logic [7:0] d, input logic [7:0] pg);
    while (phase_four !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    instr_word <= w;
    file_rd_data <= d;
    pc_page_latch <= pg;
    @(posedge ref_clk);
    #1;
    // read strobe is a one-cycle pulse, so catch it inside phase two
    rd_seen = file_rd_en_q && phase_two;
    @(posedge ref_clk);
    file_rd_data <= ~d; // stale read data must not be used
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check_inc(input logic [6:0] f, input logic [7:0] d, input logic dest);
    logic [7:0] r;
    r = d + 8'h01;
    issue({6'h0a, dest, f}, d, 8'h00);
    exp_pc = exp_pc + 13'h0001;
    chk(pc_q, exp_pc);
    chk(rd_seen, 1'b1);
    chk(file_addr_q, f);
    chk(result_data_q, r);
    chk(file_wr_en_q, dest);
    chk(w_wr_en_q, !dest);
    chk({zero_wr_en_q, zero_flag_q}, {1'b1, r == 8'h00});
  endtask

  task automatic sc_inc_wrap();
    check_inc(7'h7f, 8'hff, 1'b1);
  endtask

  task automatic sc_inc_w();
    check_inc(7'h21, 8'h13, 1'b0);
  endtask

  task automatic sc_jump_refill();
    logic z;
    z = zero_flag_q;
    issue({3'h5, 11'h5a3}, 8'h00, 8'hf7);
    chk(pc_q, 13'h15a3);
    chk(pc_load_q, 1'b1);
    chk(zero_flag_q, z);
    chk(rd_seen, 1'b0);
    issue({6'h0a, 1'b1, 7'h05}, 8'h41, 8'h00);
    chk(nop_cycle_q, 1'b1);
    chk(rd_seen, 1'b0);
    chk({file_wr_en_q, w_wr_en_q, zero_wr_en_q, zero_flag_q}, {3'h0, z});
    chk(pc_q, 13'h15a4);
    exp_pc = 13'h15a4;
  endtask

  task automatic sc_other_op();
    issue(14'h3fff, 8'h00, 8'hff);
    exp_pc = exp_pc + 13'h0001;
    chk(pc_q, exp_pc);
    chk(rd_seen, 1'b0);
    chk({file_wr_en_q, w_wr_en_q, zero_wr_en_q, pc_load_q}, 4'h0);
  endtask

  initial begin
    #20000;
    failures++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    instr_word = 14'h0000;
    pc_page_latch = 8'h00;
    file_rd_data = 8'h00;
    exp_pc = 13'h0000;
    repeat (5) @(posedge ref_clk);
    chk({phase_four, pc_q}, {1'b1, 13'h0000});
    rst_b <= 1'b1;
    #1;
    sc_inc_wrap();
    sc_jump_refill();
    sc_inc_w();
    sc_other_op();
    close_out();
  end
endmodule // tb_branch_and_increment_decode

`default_nettype wire
